// ==== logic/wtc_pkg.sv ====
// shared constants and types of the watchdog timer control block
package wtc_pkg;

   // register indices; byte address is four times the index
   localparam logic [31:0] WTC_MODE_IDX  = 32'h0000ff98;
   localparam logic [31:0] WTC_KEY_IDX   = 32'h0000ff99;
   localparam logic [31:0] WTC_CAUSE_IDX = 32'h0000ff9a;

   // mode register layout and reset value
   localparam logic [7:0] WTC_MODE_RST     = 8'h67;
   localparam logic [2:0] WTC_MODE_HI      = 3'h3;
   localparam int         WTC_SEL_STOP_BIT = 4;
   localparam int         WTC_SEL_SRC_BIT  = 3;
   localparam int         WTC_IVL_MSB      = 2;

   // key register codes
   localparam logic [7:0] WTC_KEY_CODE = 8'hac;
   localparam logic [7:0] WTC_KEY_READ = 8'h9a;

   // reset cause register
   localparam int WTC_FLAG_BIT = 4;

   // overflow intervals: 2^(base+n) ticks of the chosen source
   localparam int WTC_RING_BASE_EXP = 11;
   localparam int WTC_XTAL_BASE_EXP = 13;
   localparam int WTC_CNT_W         = 20;

   // register selection codes
   localparam logic [1:0] WTC_SEL_NONE  = 2'h0;
   localparam logic [1:0] WTC_SEL_MODE  = 2'h1;
   localparam logic [1:0] WTC_SEL_KEY   = 2'h2;
   localparam logic [1:0] WTC_SEL_CAUSE = 2'h3;

   typedef enum logic [2:0] {
      WTC_BUS_IDLE = 3'h1,
      WTC_BUS_WAIT = 3'h2,
      WTC_BUS_DATA = 3'h4
   } wtc_bus_e;

   typedef struct packed {
      wtc_bus_e               bus;
      logic                   hwrite_q;
      logic [1:0]             sel_q;
      logic                   bit_q;
      logic                   hreadyout;
      logic                   hresp;
      logic [31:0]            hrdata;
      logic [4:0]             mode;
      logic                   mode_written;
      logic [WTC_CNT_W-1:0]   count;
      logic                   reset_req;
      logic                   reset_flag;
   } wtc_state_s;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } wtc_sync_s;

endpackage : wtc_pkg

// ==== logic/wtc_tick_if.sv ====
// interface carrying count-source ticks between the watchdog modules
`timescale 1ns/1ps
interface wtc_tick_if;
   logic ring_tick;
   logic xtal_tick;
   modport src (output ring_tick, output xtal_tick);
   modport snk (input ring_tick, input xtal_tick);
endinterface : wtc_tick_if

// ==== logic/wtc_edge_sync.sv ====
// synchroniser and rising-edge detector for the two count clocks
`timescale 1ns/1ps
module wtc_edge_sync
   import wtc_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ring_osc_clk,
   input  wire logic xtal_clk,
   wtc_tick_if.src   tick
);
   wtc_sync_s q;
   wtc_sync_s next_q;
   logic [1:0] edge_hit;

   always_comb
   begin
      next_q    = q;
      next_q.s1 = {xtal_clk, ring_osc_clk};
      // first stage is read only by the second stage
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q <= '0;
      else
         q <= next_q;
   end

   for (genvar i = 0; i < 2; i++)
   begin : g_edge
      assign edge_hit[i] = q.s2[i] & ~q.s3[i];
   end

   assign tick.ring_tick = edge_hit[0];
   assign tick.xtal_tick = edge_hit[1];

endmodule : wtc_edge_sync

// ==== logic/wtc_top.sv ====
// watchdog timer control: ahb-lite registers, counter and reset request
`timescale 1ns/1ps
module wtc_top
   import wtc_pkg::*;
#(
   parameter bit FIXED_RING_OSC = 1'b1
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        bit_access,
   input  wire logic        halt_mode,
   input  wire logic        stop_mode,
   input  wire logic        ring_osc_clk,
   input  wire logic        xtal_clk,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             wdt_reset_req,
   output logic             watchdog_reset_flag
);
   import wtc_pkg::*;

   localparam logic [4:0] MODE_LOW_RST = WTC_MODE_RST[4:0];

   wtc_state_s q;
   wtc_state_s next_q;

   logic                 accept;
   logic                 wr_fire;
   logic                 mode_wr;
   logic                 key_wr;
   logic                 key_good;
   logic                 bad_mode;
   logic                 bad_key;
   logic                 stopped;
   logic                 pause;
   logic                 src_xtal;
   logic                 tick;
   logic                 overflow;
   logic                 wd_event;
   logic [1:0]           sel_d;
   logic [WTC_CNT_W-1:0] term;

   wtc_tick_if ticks ();

   wtc_edge_sync u_sync (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .ring_osc_clk (ring_osc_clk),
      .xtal_clk     (xtal_clk),
      .tick         (ticks.src)
   );

   function automatic logic [1:0] sel_of(input logic [31:0] a);
      if (a == {WTC_MODE_IDX[29:0], 2'b00})
         return WTC_SEL_MODE;
      else if (a == {WTC_KEY_IDX[29:0], 2'b00})
         return WTC_SEL_KEY;
      else if (a == {WTC_CAUSE_IDX[29:0], 2'b00})
         return WTC_SEL_CAUSE;
      else
         return WTC_SEL_NONE;
   endfunction : sel_of

   // last count value before overflow
   function automatic logic [WTC_CNT_W-1:0] term_of(input logic xt,
                                                   input logic [2:0] n);
      logic [4:0] e;
      e = xt ? 5'(WTC_XTAL_BASE_EXP) + 5'(n)
             : 5'(WTC_RING_BASE_EXP) + 5'(n);
      return WTC_CNT_W'((21'h1 << e) - 21'h1);
   endfunction : term_of

   always_comb
   begin
      next_q           = q;
      next_q.reset_req = 1'b0;
      next_q.hresp     = 1'b0;

      sel_d  = sel_of(haddr);
      accept = hsel && htrans[1] && hready;

      // bus write completes at the end of the data state
      wr_fire  = (q.bus == WTC_BUS_DATA) && q.hwrite_q;
      // bit access to the mode register is not supported; dropped
      mode_wr  = wr_fire && (q.sel_q == WTC_SEL_MODE) && !q.bit_q;
      key_wr   = wr_fire && (q.sel_q == WTC_SEL_KEY);
      key_good = key_wr && !q.bit_q && (hwdata[7:0] == WTC_KEY_CODE);

      stopped  = !FIXED_RING_OSC && q.mode[WTC_SEL_STOP_BIT];
      // fixed option never pauses; stoppable one halts in standby
      pause    = stopped || (!FIXED_RING_OSC && (halt_mode || stop_mode));
      src_xtal = !FIXED_RING_OSC && q.mode[WTC_SEL_SRC_BIT];
      tick     = src_xtal ? ticks.xtal_tick : ticks.ring_tick;
      term     = term_of(src_xtal, q.mode[WTC_IVL_MSB:0]);

      bad_mode = mode_wr && q.mode_written;
      bad_key  = key_wr && !key_good;
      overflow = !pause && tick && (q.count == term);
      wd_event = overflow || (!stopped && (bad_mode || bad_key));

      // counter runs from reset release on its own
      if (!pause && tick)
         next_q.count = q.count + WTC_CNT_W'(1);

      if (mode_wr && !q.mode_written)
      begin
         next_q.mode_written = 1'b1;
         next_q.count        = '0;
         if (FIXED_RING_OSC)
            next_q.mode = {2'b00, hwdata[WTC_IVL_MSB:0]};
         else
            next_q.mode = hwdata[4:0];
      end

      if (key_good)
         next_q.count = '0;

      // bus phases
      if (q.bus == WTC_BUS_WAIT)
      begin
         next_q.bus       = WTC_BUS_DATA;
         next_q.hreadyout = 1'b1;
      end
      else if (accept)
      begin
         next_q.hwrite_q = hwrite;
         next_q.sel_q    = sel_d;
         next_q.bit_q    = bit_access;
         next_q.hrdata   = '0;
         if (hwrite && sel_d == WTC_SEL_MODE)
         begin
            // one wait state for the mode register
            next_q.bus       = WTC_BUS_WAIT;
            next_q.hreadyout = 1'b0;
         end
         else
         begin
            next_q.bus       = WTC_BUS_DATA;
            next_q.hreadyout = 1'b1;
         end
         if (!hwrite)
         begin
            case (sel_d)
               WTC_SEL_MODE:
                  next_q.hrdata = {24'h0, WTC_MODE_HI, q.mode};
               WTC_SEL_KEY:
                  next_q.hrdata = {24'h0, WTC_KEY_READ};
               WTC_SEL_CAUSE:
               begin
                  next_q.hrdata = 32'(q.reset_flag) << WTC_FLAG_BIT;
                  next_q.reset_flag = 1'b0;
               end
               default:
                  next_q.hrdata = '0;
            endcase
         end
      end
      else
      begin
         next_q.bus       = WTC_BUS_IDLE;
         next_q.hreadyout = 1'b1;
      end

      // watchdog reset returns the block to its reset mode; set beats clear
      if (wd_event)
      begin
         next_q.reset_req    = 1'b1;
         next_q.reset_flag   = 1'b1;
         next_q.mode         = MODE_LOW_RST;
         next_q.mode_written = 1'b0;
         next_q.count        = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q              <= '0;
         q.bus          <= WTC_BUS_IDLE;
         q.hreadyout    <= 1'b1;
         q.mode         <= MODE_LOW_RST;
      end
      else
         q <= next_q;
   end

   assign hreadyout           = q.hreadyout;
   assign hresp               = q.hresp;
   assign hrdata              = q.hrdata;
   assign wdt_reset_req       = q.reset_req;
   assign watchdog_reset_flag = q.reset_flag;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   mode_reload_a: assert property (
      wd_event |=> (q.mode == MODE_LOW_RST) && !q.mode_written)
      else $error("mode not reloaded after watchdog reset");

   key_clear_a: assert property (
      key_good && !wd_event |=> q.count == '0)
      else $error("good key did not clear counter");

   bad_key_a: assert property (
      key_wr && !q.bit_q && hwdata[7:0] != WTC_KEY_CODE && !stopped
      |=> wdt_reset_req)
      else $error("wrong key gave no reset request");

   bit_key_a: assert property (
      key_wr && q.bit_q && !stopped |=> wdt_reset_req)
      else $error("bit access to key gave no reset request");

   key_read_a: assert property (
      accept && !hwrite && sel_d == WTC_SEL_KEY |=> hrdata == 32'h0000009a)
      else $error("key register read wrong value");

   mode_wait_a: assert property (
      accept && hwrite && sel_d == WTC_SEL_MODE
      |=> !hreadyout ##1 hreadyout)
      else $error("mode write wait state wrong");

   second_write_a: assert property (
      mode_wr && q.mode_written && !stopped |=> wdt_reset_req)
      else $error("second mode write gave no reset");

   stop_quiet_a: assert property (
      stopped && !overflow |=> !wdt_reset_req)
      else $error("reset raised while watchdog stopped");

   overflow_a: assert property (
      overflow |=> wdt_reset_req ##1 !wdt_reset_req)
      else $error("overflow reset request wrong");

   flag_set_a: assert property (
      wdt_reset_req |-> watchdog_reset_flag)
      else $error("reset cause flag not set");

   fixed_src_a: assert property (
      FIXED_RING_OSC |-> q.mode[4:3] == 2'b00)
      else $error("fixed option left clock select set");

   pause_hold_a: assert property (
      pause && !mode_wr && !key_wr && !wd_event |=> $stable(q.count))
      else $error("counter moved while paused");

   mode_clear_a: assert property (
      mode_wr && !q.mode_written |=> q.count == '0)
      else $error("mode write did not clear counter");

endmodule : wtc_top

// ==== dv/tb.sv ====
// self-checking bench for the watchdog timer control block
`timescale 1ns/1ps
module tb;
   import wtc_pkg::*;
   localparam logic [31:0] A_MODE  = WTC_MODE_IDX << 2;
   localparam logic [31:0] A_KEY   = WTC_KEY_IDX << 2;
   localparam logic [31:0] A_CAUSE = WTC_CAUSE_IDX << 2;
   logic        hclk, hresetn, hsel, hwrite, bit_access;
   logic        halt_mode, stop_mode, ring_osc_clk, xtal_clk;
   logic        hreadyout, hresp, wdt_reset_req, watchdog_reset_flag;
   logic        hreadyout_f, hresp_f, req_f, flag_f;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [31:0] hrdata_f, rdata_f;
   logic [7:0]  k;
   int          err_total, samples_checked, pulses, ring_n, xtal_n;
   int          waits, p0, fp0, fpulses;

   // stoppable option: exercises source select, pausing and fault masking
   wtc_top #(.FIXED_RING_OSC(1'b0)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .bit_access(bit_access), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .ring_osc_clk(ring_osc_clk),
      .xtal_clk(xtal_clk), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .wdt_reset_req(wdt_reset_req),
      .watchdog_reset_flag(watchdog_reset_flag));

   // fixed option on the same bus: clock select ignored, never pauses
   wtc_top #(.FIXED_RING_OSC(1'b1)) fix_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout_f), .bit_access(bit_access), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .ring_osc_clk(ring_osc_clk),
      .xtal_clk(xtal_clk), .hreadyout(hreadyout_f), .hresp(hresp_f),
      .hrdata(hrdata_f), .wdt_reset_req(req_f),
      .watchdog_reset_flag(flag_f));

   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // count clocks off any hclk phase so the synchroniser sees real skew
   initial
   begin
      ring_osc_clk = 1'b0;
      #3.3;
      forever #10 ring_osc_clk = ~ring_osc_clk;
   end
   initial
   begin
      xtal_clk = 1'b0;
      #1.7;
      forever #9.3 xtal_clk = ~xtal_clk;
   end

   // reference count of source edges, frozen while the cpu sleeps
   always @(posedge ring_osc_clk) if (!halt_mode && !stop_mode) ring_n++;
   always @(posedge xtal_clk) if (!halt_mode && !stop_mode) xtal_n++;
   always @(posedge hclk) if (wdt_reset_req === 1'b1) pulses++;
   always @(posedge hclk) if (req_f === 1'b1) fpulses++;

   task automatic finish_test;
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // sync delay leaves four edges of slack at either end
   task automatic chk_rng(input string nm, input int e, input int g);
      samples_checked++;
      if (g < e - 4 || g > e + 4)
      begin
         err_total++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : chk_rng

   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [7:0] d, input logic b);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      bit_access <= b;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge hclk);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      bit_access <= 1'b0;
      hwdata <= {24'($urandom), d};
      waits = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && waits < 20)
      begin
         waits++;
         @(posedge hclk);
      end
      rdata = hrdata;
      rdata_f = hrdata_f;
      chk("hresp", 32'h0, {30'h0, hresp_f, hresp});
      if (n >= 20 || waits >= 20)
         chk("bus ready", 32'h1, 32'h0);
   endtask : bus

   task automatic rd_chk(input string nm, input logic [31:0] a,
                         input logic [31:0] e);
      bus(a, 1'b0, 8'h00, 1'b0);
      chk(nm, e, rdata);
   endtask : rd_chk

   // write and count reset requests raised shortly after it
   task automatic fault(input string nm, input logic [31:0] a,
                        input logic [7:0] d, input logic b, input int e);
      p0 = pulses;
      fp0 = fpulses;
      bus(a, 1'b1, d, b);
      repeat (4) @(posedge hclk);
      chk(nm, 32'(e), 32'(pulses - p0));
   endtask : fault

   task automatic wait_ovf(input int lim);
      p0 = pulses;
      while (pulses == p0 && lim > 0)
      begin
         lim--;
         @(posedge hclk);
      end
   endtask : wait_ovf

   initial
   begin
      repeat (90000) @(posedge hclk);
      err_total++;
      $display("[ERR] run time expected done seen hang");
      finish_test;
   end

   initial
   begin
      void'($urandom(32'ha177));
      {hresetn, hsel, hwrite, bit_access, halt_mode, stop_mode} = 6'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      {err_total, samples_checked, pulses, ring_n, xtal_n} = '0;
      fpulses = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("mode reset", A_MODE, {24'h0, WTC_MODE_RST});
      rd_chk("key read", A_KEY, {24'h0, WTC_KEY_READ});
      rd_chk("unmapped", A_CAUSE + 32'h8, 32'h0);
      rd_chk("cause reset", A_CAUSE, 32'h0);
      fault("good key", A_KEY, WTC_KEY_CODE, 1'b0, 0);
      rd_chk("key after write", A_KEY, 32'h9a);
      for (int i = 0; i < 4; i++)
      begin
         k = 8'($urandom);
         if (k == WTC_KEY_CODE)
            k = ~k;
         fault("bad key", A_KEY, k, 1'b0, 1);
         chk("flags", 32'h3, {30'h0, flag_f, watchdog_reset_flag});
         rd_chk("cause flag", A_CAUSE, 32'h10);
         rd_chk("cause cleared", A_CAUSE, 32'h0);
         chk("flags 0", 32'h0, {30'h0, flag_f, watchdog_reset_flag});
      end
      fault("bit key", A_KEY, WTC_KEY_CODE, 1'b1, 1);
      fault("first mode", A_MODE, 8'h60, 1'b0, 0);
      rd_chk("mode readback", A_MODE, 32'h60);
      fault("second mode", A_MODE, 8'h60, 1'b0, 1);
      rd_chk("mode reloaded", A_MODE, 32'h67);
      // counter runs on the default setting before the write
      repeat (800) @(posedge hclk);
      bus(A_MODE, 1'b1, 8'h68, 1'b0);
      xtal_n = 0;
      chk("mode wait", 32'h1, 32'(waits));
      wait_ovf(40000);
      chk_rng("xtal overflow", 8192, xtal_n);
      bus(A_MODE, 1'b1, 8'h60, 1'b0);
      repeat (2000) @(posedge hclk);
      fault("key restart", A_KEY, WTC_KEY_CODE, 1'b0, 0);
      ring_n = 0;
      repeat (2000) @(posedge hclk);
      halt_mode <= 1'b1;
      repeat (1500) @(posedge hclk);
      halt_mode <= 1'b0;
      stop_mode <= 1'b1;
      repeat (500) @(posedge hclk);
      stop_mode <= 1'b0;
      // fixed copy keeps counting through halt and stop, so it trips first
      repeat (4600) @(posedge hclk);
      chk("fixed no pause", 32'h1, 32'(fpulses - fp0));
      chk("paused no ovf", 32'h0, 32'(pulses - p0));
      wait_ovf(20000);
      chk_rng("ring overflow", 2048, ring_n);
      bus(A_MODE, 1'b1, 8'h70, 1'b0);
      rd_chk("stop mode set", A_MODE, 32'h70);
      chk("fixed mode", 32'h60, rdata_f);
      fault("stopped bad key", A_KEY, 8'h00, 1'b0, 0);
      chk("fixed bad key", 32'h1, 32'(fpulses - fp0));
      fault("stopped bit key", A_KEY, WTC_KEY_CODE, 1'b1, 0);
      chk("fixed bit key", 32'h1, 32'(fpulses - fp0));
      fault("stopped mode", A_MODE, 8'h60, 1'b0, 0);
      rd_chk("stopped mode kept", A_MODE, 32'h70);
      p0 = pulses;
      fp0 = fpulses;
      repeat (9000) @(posedge hclk);
      chk("stopped count", 32'h0, 32'(pulses - p0));
      chk("fixed runs on", 32'h1, 32'(fpulses - fp0));
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("mode rereset", A_MODE, 32'h67);
      chk("fixed rereset", 32'h67, rdata_f);
      finish_test;
   end
endmodule : tb
